// *** include/srpa_pkg.sv ***
// shared constants for the serial parameter access link
// assumes both ends and the descriptor table use these names
package srpa_pkg;
    // command header fields
    localparam logic [1:0] CT_DATA = 2'h1;
    localparam logic [1:0] CT_PROC = 2'h2;
    localparam int HB_WR = 5;
    localparam int HB_RID = 4;
    localparam int HB_AI = 3;
    localparam int HB_AS = 2;
    // stored procedure table
    localparam int PROC_COUNT = 64;
    localparam int PROC_PITCH_LOG2 = 3;
    // device address space
    localparam int MEM_BYTES = 1024;
    localparam logic [15:0] DESC_BASE = 16'h0400;
    localparam logic [15:0] TOCP_LOC = 16'h0400;
    localparam logic [7:0] TOC_OFS = 8'h10;
    localparam logic [7:0] PD_OFS = 8'h20;
    localparam logic [7:0] MD_OFS = 8'h40;
    // descriptor records
    localparam logic [7:0] REC_PROCESS = 8'hA0;
    localparam logic [7:0] REC_MODE = 8'hB0;
    localparam logic [7:0] MODE_HW = 8'h00;
    localparam logic [7:0] MODE_SW = 8'h01;
    localparam logic [7:0] PD_SIZE = 8'h01;
    localparam logic [7:0] PD_TYPE = 8'h02;
    localparam logic [7:0] PD_DIR = 8'h03;
    localparam logic [7:0] PD_MIN = 8'h04;
    localparam logic [7:0] PD_MAX = 8'h08;
    localparam logic [7:0] PD_PARAM = 8'h0A;
    localparam logic [7:0] PD_UNIT = 8'h0C;
    localparam logic [7:0] MD_INDEX = 8'h01;
    localparam logic [7:0] MD_TYPE = 8'h02;
    localparam logic [7:0] MD_NAME = 8'h04;
    // host registers, byte addresses
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_CS = 8'h08;
    localparam logic [7:0] REG_IF0 = 8'h0C;
    localparam logic [7:0] REG_IF1 = 8'h10;
    localparam logic [7:0] REG_IF2 = 8'h14;
    // host command opcodes, command bits 15:8; start read header; present channel mask
    localparam logic [7:0] OP_STOP = 8'h08;
    localparam logic [7:0] OP_NORMAL = 8'h09;
    localparam logic [7:0] OP_SETUP = 8'h0F;
    localparam logic [7:0] OP_TRANSFER_TRIGGER_COMMAND = 8'h10;
    localparam logic [7:0] HDR_RD_WORD_AS = 8'h45;
    localparam logic [7:0] CH_PRESENT = 8'h01;
    // reply wait
    localparam int CLK_MHZ = 100;
    localparam int TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

    function automatic logic [3:0] size_bytes(input logic [1:0] code);
        size_bytes = 4'h1 << code;
    endfunction
endpackage

// *** include/srpa_link_if.sv ***
// byte link between host controller and remote device
// assumes both ends share one clock; valid/ready on each direction
`timescale 1ns/1ps
`default_nettype none
interface srpa_link_if;
    logic [7:0] h2d_data;
    logic h2d_valid;
    logic h2d_ready;
    logic [7:0] d2h_data;
    logic d2h_valid;
    logic d2h_ready;
    modport dev (input h2d_data, input h2d_valid, output h2d_ready,
                 output d2h_data, output d2h_valid, input d2h_ready);
    modport host (output h2d_data, output h2d_valid, input h2d_ready,
                  input d2h_data, input d2h_valid, output d2h_ready);
endinterface
`default_nettype wire

// *** logic/srpa_desc_rom.sv ***
// self-description tables of the remote device
// assumes offsets relative to the descriptor base
`timescale 1ns/1ps
`default_nettype none
module srpa_desc_rom #(
    parameter logic [7:0] DATA_SIZE = 8'h08,
    parameter logic [7:0] DATA_TYPE = 8'h01,
    parameter logic [7:0] DATA_DIR = 8'h00,
    parameter logic [31:0] RANGE_MIN = 32'h0000_0000,
    parameter logic [15:0] RANGE_MAX_LO = 16'h00FF,
    parameter logic [15:0] PARAM_LOC = 16'h0200,
    parameter logic [7:0] MODE_INDEX = 8'h00,
    parameter logic [7:0] MODE_TYPE = srpa_pkg::MODE_SW
)(
    input wire logic [7:0] ofs,
    output logic [7:0] q
);
    localparam logic [15:0] TOC_A = srpa_pkg::DESC_BASE + {8'h00, srpa_pkg::TOC_OFS};
    localparam logic [15:0] PD_A = srpa_pkg::DESC_BASE + {8'h00, srpa_pkg::PD_OFS};
    localparam logic [15:0] MD_A = srpa_pkg::DESC_BASE + {8'h00, srpa_pkg::MD_OFS};
    localparam logic [7:0] P = srpa_pkg::PD_OFS;
    localparam logic [7:0] M = srpa_pkg::MD_OFS;
    localparam logic [7:0] T = srpa_pkg::TOC_OFS;
    localparam logic [7:0] U = P + srpa_pkg::PD_UNIT;

    always_comb
    begin
        case (ofs)
            8'h00: q = TOC_A[7:0]; // [RQ18]
            8'h01: q = TOC_A[15:8];
            T: q = PD_A[7:0]; // [RQ19]
            T + 8'h01: q = PD_A[15:8];
            T + 8'h02: q = MD_A[7:0];
            T + 8'h03: q = MD_A[15:8];
            P: q = srpa_pkg::REC_PROCESS; // [RQ20]
            P + srpa_pkg::PD_SIZE: q = DATA_SIZE; // [RQ21]
            P + srpa_pkg::PD_TYPE: q = DATA_TYPE;
            P + srpa_pkg::PD_DIR: q = DATA_DIR;
            P + srpa_pkg::PD_MIN: q = RANGE_MIN[7:0];
            P + srpa_pkg::PD_MIN + 8'h01: q = RANGE_MIN[15:8];
            P + srpa_pkg::PD_MIN + 8'h02: q = RANGE_MIN[23:16];
            P + srpa_pkg::PD_MIN + 8'h03: q = RANGE_MIN[31:24];
            P + srpa_pkg::PD_MAX: q = RANGE_MAX_LO[7:0];
            P + srpa_pkg::PD_MAX + 8'h01: q = RANGE_MAX_LO[15:8];
            P + srpa_pkg::PD_PARAM: q = PARAM_LOC[7:0];
            P + srpa_pkg::PD_PARAM + 8'h01: q = PARAM_LOC[15:8];
            U: q = 8'h56; // [RQ22]
            U + 8'h02: q = 8'h6F;
            U + 8'h03: q = 8'h75;
            U + 8'h04: q = 8'h74;
            M: q = srpa_pkg::REC_MODE; // [RQ20]
            M + srpa_pkg::MD_INDEX: q = MODE_INDEX; // [RQ23]
            M + srpa_pkg::MD_TYPE: q = MODE_TYPE; // [RQ24]
            M + srpa_pkg::MD_NAME: q = 8'h69;
            M + srpa_pkg::MD_NAME + 8'h01: q = 8'h6F;
            default: q = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// *** logic/srpa_device.sv ***
// remote device end: command interpreter with address pointer,
// byte memory, stored procedures and descriptor tables
// assumes the host end on the same mclk via srpa_link_if
//
// Overview of operation
// RQ1: header top bits 01b mean data read/write
// RQ2: header bit 5 set writes, clear reads
// RQ3: bit 4 picks procedure data, procedures only
// RQ4: bit 3 post-increments pointer by size
// RQ5: bit 2 set means two address bytes
// RQ6: bits 1:0 give 1,2,4,8 bytes
// RQ7: multi-byte transfers use rising consecutive addresses
// RQ8: device only answers host commands, header first
// RQ9: 64 stored procedures run by one byte
// RQ10: address low byte then high, before data
// RQ11: host stops all before setup access
// RQ12: host setup-starts channels, waits command clear
// RQ13: data register flags channels failing start
// RQ14: host puts write value in interface 0
// RQ15: host writes code 0x65 plus address to CS
// RQ16: codes 0x64..0x67 write 1,2,4,8 bytes
// RQ17: host waits clear then checks data zero
// RQ18: interface 2 holds table pointer, zero unsupported
// RQ19: table of 16-bit words ends at zero
// RQ20: record type 0xA0 process, 0xB0 mode
// RQ21: process descriptor field offsets fixed
// RQ22: strings zero-terminated, name follows unit
// RQ23: mode descriptor index, type, name offsets
// RQ24: mode type 0x00 hardware, 0x01 software
`timescale 1ns/1ps
`default_nettype none
module srpa_device #(
    parameter int MEM_BYTES = srpa_pkg::MEM_BYTES
)(
    input wire logic mclk,
    input wire logic rst,
    srpa_link_if.dev link,
    output logic param_wr_valid,
    output logic [15:0] param_wr_addr,
    output logic [7:0] param_wr_data,
    output logic proc_active
);
    localparam int MW = $clog2(MEM_BYTES);
    typedef enum logic [2:0] {S_HDR, S_ALO, S_AHI, S_WR, S_RD} srpa_dstate_t;

    srpa_dstate_t state;
    srpa_dstate_t next_state;
    logic [7:0] hdr;
    logic [15:0] base;
    logic [15:0] ptr;
    logic [3:0] cnt;
    logic in_proc;
    logic next_in_proc;
    logic next_rid;
    logic finish;
    logic [15:0] proc_ptr;
    logic [7:0] mem [MEM_BYTES];

    // stream is wanted only where the byte does not come from a procedure
    function automatic logic wants_stream(input srpa_dstate_t st, input logic inp, input logic procedure_includes_data_bit);
        case (st)
            S_HDR, S_ALO, S_AHI: wants_stream = !inp;
            S_WR: wants_stream = !(inp && procedure_includes_data_bit);
            default: wants_stream = 1'b0;
        endcase
    endfunction

    function automatic logic in_rom(input logic [15:0] a);
        in_rom = (a >= srpa_pkg::DESC_BASE) && (a < srpa_pkg::DESC_BASE + 16'h0100);
    endfunction

    wire [3:0] nbytes = srpa_pkg::size_bytes(hdr[1:0]); // [RQ6]
    wire src_proc = in_proc && (state != S_RD) && (state != S_WR || hdr[srpa_pkg::HB_RID]); // [RQ3]
    wire [15:0] cur_addr = base + {12'h000, cnt}; // [RQ7]
    wire [15:0] rd_addr = src_proc ? proc_ptr : cur_addr;
    wire [15:0] rom_ofs = rd_addr - srpa_pkg::DESC_BASE;
    wire [7:0] rom_q;
    wire rd_in_mem = rd_addr < 16'(MEM_BYTES);
    wire [7:0] rd_byte = in_rom(rd_addr) ? rom_q : (rd_in_mem ? mem[rd_addr[MW-1:0]] : 8'h00);
    wire got = src_proc || (link.h2d_valid && link.h2d_ready); // [RQ8]
    wire [7:0] in_byte = src_proc ? rd_byte : link.h2d_data;
    wire is_data = in_byte[7:6] == srpa_pkg::CT_DATA; // [RQ1]
    wire is_proc = in_byte[7:6] == srpa_pkg::CT_PROC;
    wire last_wr = cnt == nbytes - 4'h1;
    wire rd_step = !link.d2h_valid || link.d2h_ready;
    wire wr_mem = (state == S_WR) && got && (cur_addr < 16'(MEM_BYTES));
    wire [15:0] proc_start = {10'h000, in_byte[5:0]} << srpa_pkg::PROC_PITCH_LOG2; // [RQ9]

    srpa_desc_rom u_rom (
        .ofs(rom_ofs[7:0]),
        .q(rom_q)
    );

    always_comb
    begin
        next_state = state;
        next_in_proc = in_proc;
        next_rid = hdr[srpa_pkg::HB_RID];
        finish = 1'b0;
        case (state)
            S_HDR:
            begin
                if (got && is_data)
                begin
                    next_rid = in_byte[srpa_pkg::HB_RID];
                    if (in_byte[srpa_pkg::HB_AS]) // [RQ5]
                        next_state = S_ALO;
                    else if (in_byte[srpa_pkg::HB_WR]) // [RQ2]
                        next_state = S_WR;
                    else
                        next_state = S_RD;
                end
                else if (got && is_proc && !in_proc)
                    next_in_proc = 1'b1; // [RQ9]
                else if (got)
                    next_in_proc = 1'b0;
            end
            S_ALO:
            begin
                if (got)
                    next_state = S_AHI; // [RQ10]
            end
            S_AHI:
            begin
                if (got)
                    next_state = hdr[srpa_pkg::HB_WR] ? S_WR : S_RD;
            end
            S_WR:
            begin
                if (got && last_wr)
                begin
                    next_state = S_HDR;
                    finish = 1'b1;
                end
            end
            S_RD:
            begin
                if (rd_step && cnt == nbytes)
                begin
                    next_state = S_HDR;
                    finish = 1'b1;
                end
            end
            default: next_state = S_HDR;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (wr_mem)
            mem[cur_addr[MW-1:0]] <= in_byte; // [RQ2]
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= S_HDR;
            in_proc <= 1'b0;
            hdr <= 8'h00;
            base <= 16'h0000;
            ptr <= 16'h0000;
            cnt <= 4'h0;
            proc_ptr <= 16'h0000;
            link.h2d_ready <= 1'b0;
            link.d2h_valid <= 1'b0;
            link.d2h_data <= 8'h00;
            param_wr_valid <= 1'b0;
            param_wr_addr <= 16'h0000;
            param_wr_data <= 8'h00;
            proc_active <= 1'b0;
        end
        else
        begin
            state <= next_state;
            in_proc <= next_in_proc;
            proc_active <= next_in_proc;
            link.h2d_ready <= wants_stream(next_state, next_in_proc, next_rid); // [RQ8]
            param_wr_valid <= 1'b0;
            if (src_proc && got)
                proc_ptr <= proc_ptr + 16'h0001;
            case (state)
                S_HDR:
                begin
                    if (got)
                    begin
                        hdr <= in_byte;
                        cnt <= 4'h0;
                        base <= ptr; // [RQ5]
                        if (is_proc && !in_proc)
                            proc_ptr <= proc_start; // [RQ9]
                    end
                end
                S_ALO:
                begin
                    if (got)
                        base[7:0] <= in_byte; // [RQ10]
                end
                S_AHI:
                begin
                    if (got)
                        base[15:8] <= in_byte; // [RQ10]
                end
                S_WR:
                begin
                    if (got)
                    begin
                        param_wr_valid <= 1'b1;
                        param_wr_addr <= cur_addr; // [RQ7]
                        param_wr_data <= in_byte;
                        cnt <= cnt + 4'h1;
                    end
                end
                S_RD:
                begin
                    if (rd_step && cnt < nbytes)
                    begin
                        link.d2h_data <= rd_byte; // [RQ7]
                        link.d2h_valid <= 1'b1;
                        cnt <= cnt + 4'h1;
                    end
                    else if (rd_step)
                        link.d2h_valid <= 1'b0;
                end
                default: cnt <= 4'h0;
            endcase
            if (finish)
                ptr <= hdr[srpa_pkg::HB_AI] ? base + {12'h000, nbytes} : base; // [RQ4]
        end
    end
endmodule
`default_nettype wire

// *** logic/srpa_host.sv ***
// host end: command, data, CS and interface registers over APB,
// runs start and transfer commands over the byte link
// assumes a device end on the same mclk; channel 0 only is wired
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module srpa_host #(
    parameter int TIMEOUT_CYC = srpa_pkg::TIMEOUT_CYC
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    srpa_link_if.host link
);
    typedef enum logic [1:0] {T_IDLE, T_SEND, T_RECV} srpa_hstate_t;

    srpa_hstate_t tst;
    logic [15:0] cmd;
    logic [31:0] fault;
    logic [31:0] cs;
    logic [31:0] if0;
    logic [31:0] if1;
    logic [31:0] if2;
    logic go;
    logic go_start;
    logic abort;
    logic to_if2;
    logic [7:0] xhdr;
    logic [15:0] xaddr;
    logic [63:0] xwd;
    logic [63:0] rbuf;
    logic [3:0] idx;
    logic [31:0] tmo;
    logic done;
    logic timed_out;

    function automatic logic [7:0] tx_byte(input logic [7:0] h, input logic [15:0] a,
                                           input logic [63:0] wd, input logic [3:0] i);
        logic [3:0] k;
        k = h[srpa_pkg::HB_AS] ? i - 4'h3 : i - 4'h1;
        if (i == 4'h0)
            tx_byte = h;
        else if (h[srpa_pkg::HB_AS] && i == 4'h1)
            tx_byte = a[7:0];
        else if (h[srpa_pkg::HB_AS] && i == 4'h2)
            tx_byte = a[15:8];
        else
            tx_byte = 8'(wd >> {k[2:0], 3'h0});
    endfunction

    wire access = psel && penable && !pready;
    wire wr_en = psel && penable && pready && pwrite;
    wire [7:0] op = pwdata[15:8];
    wire [7:0] mask = pwdata[7:0];
    wire sel_cmd = paddr == srpa_pkg::REG_CMD;
    wire mapped = sel_cmd || paddr == srpa_pkg::REG_DATA || paddr == srpa_pkg::REG_CS
        || paddr == srpa_pkg::REG_IF0 || paddr == srpa_pkg::REG_IF1 || paddr == srpa_pkg::REG_IF2;
    wire is_start = op == srpa_pkg::OP_SETUP || op == srpa_pkg::OP_NORMAL;
    wire runs = (is_start || op == srpa_pkg::OP_TRANSFER_TRIGGER_COMMAND) && mask[0];
    wire cmd_ok = wr_en && sel_cmd && (cmd == 16'h0000 || op == srpa_pkg::OP_STOP);
    wire [3:0] n = srpa_pkg::size_bytes(xhdr[1:0]); // [RQ16]
    wire is_wr = xhdr[srpa_pkg::HB_WR];
    wire [3:0] tx_len = 4'h1 + (xhdr[srpa_pkg::HB_AS] ? 4'h2 : 4'h0) + (is_wr ? n : 4'h0);
    wire [3:0] rx_len = is_wr ? 4'h0 : n;
    wire [31:0] rd_mux = paddr == srpa_pkg::REG_CMD ? {16'h0000, cmd}
        : paddr == srpa_pkg::REG_DATA ? fault : paddr == srpa_pkg::REG_CS ? cs
        : paddr == srpa_pkg::REG_IF0 ? if0 : paddr == srpa_pkg::REG_IF1 ? if1
        : paddr == srpa_pkg::REG_IF2 ? if2 : 32'h0000_0000;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            cmd <= 16'h0000;
            fault <= 32'h0000_0000;
            cs <= 32'h0000_0000;
            if0 <= 32'h0000_0000;
            if1 <= 32'h0000_0000;
            if2 <= 32'h0000_0000;
            go <= 1'b0;
            go_start <= 1'b0;
            abort <= 1'b0;
        end
        else
        begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= access && !pwrite ? rd_mux : 32'h0000_0000;
            go <= cmd_ok && runs && op != srpa_pkg::OP_STOP;
            go_start <= is_start;
            abort <= cmd_ok && op == srpa_pkg::OP_STOP; // [RQ11]
            if (cmd_ok)
            begin
                cmd <= (runs && op != srpa_pkg::OP_STOP) ? pwdata[15:0] : 16'h0000; // [RQ12]
                fault <= {24'h000000, mask & ~srpa_pkg::CH_PRESENT}; // [RQ13]
            end
            else if (done)
            begin
                cmd <= 16'h0000; // [RQ17]
                fault[0] <= timed_out; // [RQ13]
                if (!timed_out && to_if2)
                    if2 <= {16'h0000, rbuf[15:0]}; // [RQ18]
                else if (!timed_out && rx_len != 4'h0)
                begin
                    if0 <= rbuf[31:0];
                    if1 <= rbuf[63:32];
                end
            end
            if (wr_en && paddr == srpa_pkg::REG_CS)
                cs <= pwdata; // [RQ15]
            if (wr_en && paddr == srpa_pkg::REG_IF0)
                if0 <= pwdata; // [RQ14]
            if (wr_en && paddr == srpa_pkg::REG_IF1)
                if1 <= pwdata;
            if (wr_en && paddr == srpa_pkg::REG_IF2)
                if2 <= pwdata;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst || abort)
        begin
            tst <= T_IDLE;
            link.h2d_valid <= 1'b0;
            link.h2d_data <= 8'h00;
            link.d2h_ready <= 1'b0;
            xhdr <= 8'h00;
            xaddr <= 16'h0000;
            xwd <= 64'h0;
            rbuf <= 64'h0;
            to_if2 <= 1'b0;
            idx <= 4'h0;
            tmo <= 32'h0;
            done <= 1'b0;
            timed_out <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            tmo <= (tst != T_IDLE) ? tmo + 32'h1 : 32'h0;
            if (tst != T_IDLE && tmo == 32'(TIMEOUT_CYC))
            begin
                tst <= T_IDLE;
                link.h2d_valid <= 1'b0;
                link.d2h_ready <= 1'b0;
                done <= 1'b1;
                timed_out <= 1'b1;
            end
            else
            begin
                case (tst)
                    T_IDLE:
                    begin
                        if (go)
                        begin
                            xhdr <= go_start ? srpa_pkg::HDR_RD_WORD_AS : cs[31:24]; // [RQ15]
                            xaddr <= go_start ? srpa_pkg::TOCP_LOC : cs[15:0]; // [RQ18]
                            xwd <= {if1, if0}; // [RQ14]
                            to_if2 <= go_start;
                            rbuf <= 64'h0;
                            idx <= 4'h0;
                            timed_out <= 1'b0;
                            tst <= T_SEND;
                        end
                    end
                    T_SEND:
                    begin
                        if (link.h2d_valid && link.h2d_ready)
                            tmo <= 32'h0;
                        if (!link.h2d_valid || link.h2d_ready)
                        begin
                            if (idx < tx_len)
                            begin
                                link.h2d_data <= tx_byte(xhdr, xaddr, xwd, idx); // [RQ10]
                                link.h2d_valid <= 1'b1;
                                idx <= idx + 4'h1;
                            end
                            else
                            begin
                                link.h2d_valid <= 1'b0;
                                idx <= 4'h0;
                                link.d2h_ready <= rx_len != 4'h0;
                                tst <= rx_len != 4'h0 ? T_RECV : T_IDLE;
                                done <= rx_len == 4'h0;
                            end
                        end
                    end
                    T_RECV:
                    begin
                        if (link.d2h_valid && link.d2h_ready)
                        begin
                            rbuf[{idx[2:0], 3'h0} +: 8] <= link.d2h_data; // [RQ19]
                            idx <= idx + 4'h1;
                            tmo <= 32'h0;
                            if (idx == rx_len - 4'h1)
                            begin
                                link.d2h_ready <= 1'b0;
                                tst <= T_IDLE;
                                done <= 1'b1;
                            end
                        end
                    end
                    default: tst <= T_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/srpa_link_assertions.sv ***
// link checks between host and device ends
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module srpa_link_assertions(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_valid,
    input wire logic h2d_ready,
    input wire logic [7:0] d2h_data,
    input wire logic d2h_valid,
    input wire logic d2h_ready
);
default clocking cb @(posedge mclk);
endclocking
default disable iff (rst);
logic seen;
always_ff @(posedge mclk)
    seen <= rst ? 1'b0 : (seen | (h2d_valid & h2d_ready));
a_hdr_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("host byte changed before taken");
a_reply_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("device byte changed before taken");
a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0) rst |=> !d2h_valid && !h2d_ready)
    else $error("device active in reset");
a_ready_release: assert property ($fell(rst) |-> ##[0:2] h2d_ready)
    else $error("device not ready after reset");
a_answer_only: assert property (d2h_valid |-> seen)
    else $error("device spoke unasked");
a_half_duplex: assert property (d2h_valid && d2h_ready |-> !(h2d_valid && h2d_ready))
    else $error("device took and sent at once");
a_ready_returns: assert property (h2d_valid && !h2d_ready |-> ##[1:64] h2d_ready)
    else $error("device stalled too long");
a_reply_taken: assert property (d2h_valid |-> ##[0:16] d2h_ready)
    else $error("host left reply untaken");
endmodule
`default_nettype wire

// *** testbench/serial_remote_param_access_bench.sv ***
// bench for the host and device ends over apb
// assumes both ends and the link share mclk
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin checked++; if ((s)!==(e)) begin fails++; $display("[ERR] %s exp %h got %h",n,e,s); end end
module serial_remote_param_access_bench;
logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pwv;
logic [7:0] paddr = 0;
logic [15:0] pwa;
logic [7:0] pwd;
logic [31:0] pwdata = 0, prdata, rd, d0, d1, m;
logic [64:0] q[$];
logic [15:0] da[7] = '{16'h0410, 16'h0412, 16'h0414, 16'h0420, 16'h0440, 16'h0442, 16'h042A};
logic [15:0] de[7] = '{16'h0420, 16'h0440, 16'h0000, 16'h00A0, 16'h00B0, 16'h0001, 16'h0200};
int fails = 0, checked = 0, nwr = 0, cyc = 0, i;
srpa_link_if link();
srpa_host #(.TIMEOUT_CYC(200)) u_srpa_host(.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
srpa_device u_srpa_device(.mclk(mclk), .rst(rst), .link(link.dev), .param_wr_valid(pwv),
    .param_wr_addr(pwa), .param_wr_data(pwd), .proc_active());
srpa_link_assertions u_srpa_link_assertions(.mclk(mclk), .rst(rst), .h2d_data(link.h2d_data),
    .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data),
    .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
always #5 mclk = ~mclk;
task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
always @(posedge mclk)
begin
    cyc++;
    if (pwv === 1'b1)
        nwr++;
    if (cyc > 60000)
    begin
        fails++;
        finish_test();
    end
end
always @(posedge mclk)
    if (psel && penable && pready === 1'b1)
    begin
        logic [64:0] e;
        e = q.pop_front();
        `CHK("prdata", e[31:0], prdata & e[63:32])
        `CHK("pslverr", e[64], pslverr)
    end
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk, input logic er);
    q.push_back({er, mk, d & mk});
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1)
        @(posedge mclk);
    rd = prdata;
    psel <= 0;
    penable <= 0;
endtask
task automatic cmd(input logic [31:0] c);
    apb(1, srpa_pkg::REG_CMD, c, 0, 0);
    do
        apb(0, srpa_pkg::REG_CMD, 0, 0, 0);
    while (rd !== 32'h0);
endtask
task automatic remote(input logic [7:0] h, input logic [15:0] a);
    apb(1, srpa_pkg::REG_CS, {h, 8'h00, a}, 0, 0);
    cmd(32'h1001);
    apb(0, srpa_pkg::REG_DATA, 0, '1, 0);
endtask
initial
begin
    void'($urandom(11560));
    repeat (8) @(posedge mclk);
    rst <= 0;
    apb(0, srpa_pkg::REG_CMD, 0, '1, 0);
    cmd(32'h800);
    cmd(32'hF03);
    apb(0, srpa_pkg::REG_DATA, 32'h2, '1, 0);
    cmd(32'hF01);
    apb(0, srpa_pkg::REG_DATA, 0, '1, 0);
    apb(0, srpa_pkg::REG_IF2, 32'h0410, 32'hFFFF, 0);
    apb(0, 8'h18, 0, '1, 1);
    for (i = 0; i < 4; i++)
    begin
        d0 = $urandom;
        d1 = $urandom;
        m = (i > 1) ? '1 : (32'h1 << (8 << i)) - 1;
        apb(1, srpa_pkg::REG_IF0, d0, 0, 0);
        apb(1, srpa_pkg::REG_IF1, d1, 0, 0);
        remote(8'h64 + 8'(i), 16'h0200 + 16'(i * 8));
        apb(1, srpa_pkg::REG_IF0, ~d0, 0, 0);
        apb(1, srpa_pkg::REG_IF1, ~d1, 0, 0);
        remote(8'h44 + 8'(i), 16'h0200 + 16'(i * 8));
        apb(0, srpa_pkg::REG_IF0, d0 & m, '1, 0);
        apb(0, srpa_pkg::REG_IF1, (i == 3) ? d1 : 32'h0, '1, 0);
    end
    `CHK("writes", 15, nwr)
    `CHK("wr_addr", 16'h021F, pwa)
    `CHK("wr_data", d1[31:24], pwd)
    apb(1, srpa_pkg::REG_IF0, d0, 0, 0);
    remote(8'h6D, 16'h0300);
    apb(1, srpa_pkg::REG_IF0, d1, 0, 0);
    remote(8'h61, 16'h0000);
    remote(8'h46, 16'h0300);
    apb(0, srpa_pkg::REG_IF0, {d1[15:0], d0[15:0]}, '1, 0);
    apb(1, srpa_pkg::REG_IF0, ~d0, 0, 0);
    remote(8'h41, 16'h0000);
    apb(0, srpa_pkg::REG_IF0, {16'h0, d0[15:0]}, '1, 0);
    apb(1, srpa_pkg::REG_IF0, 32'h0003_0044, 0, 0);
    apb(1, srpa_pkg::REG_IF1, 0, 0, 0);
    remote(8'h67, 16'h0000);
    remote(8'h80, 16'h0000);
    apb(0, srpa_pkg::REG_IF0, {24'h0, d0[7:0]}, '1, 0);
    for (i = 0; i < 7; i++)
    begin
        remote((i < 3 || i == 6) ? 8'h45 : 8'h44, da[i]);
        apb(0, srpa_pkg::REG_IF0, {16'h0, de[i]}, '1, 0);
    end
    finish_test();
end
endmodule
`default_nettype wire
